//--- core/ubg_ctrl.sv
// Purpose: Register file, interrupt gating and baud generator top.
// Assumes: ref_clk_i is a 24 MHz reference sampled in the 25 MHz domain.
// Notes:   Divisor latch access is bit 7 of the speed register.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "ubg_cfg.svh"
module ubg_ctrl (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_empty_i,
  input  wire logic       line_status_i,
  input  wire logic       modem_change_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  output logic            ev_irq_o,
  output logic            tick16_o
);
  typedef struct packed {
    logic [2:0]  rsync;
    logic        ref_lvl;
    logic        ref_en;
    logic [7:0]  irq_enable;
    logic [7:0]  div_lo;
    logic [7:0]  div_hi;
    logic [7:0]  scratch_byte;
    logic [7:0]  speed_mode_config;
    logic [7:0]  modem_control_reg;
    logic [3:0]  ev_stat;
    logic [3:0]  ev_mask;
    logic [3:0]  src_prev;
    logic [7:0]  rdata;
    logic        irq;
    logic        ev_irq;
  } ubg_ctl_st_t;

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  ubg_ctl_st_t st_reg;
  ubg_ctl_st_t st_next;
  logic [3:0]  src;
  logic        dlab;

  ubg_tick_if tif ();

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign src = {modem_change_i, line_status_i, tx_empty_i, rx_ready_i};
  assign dlab = st_reg.speed_mode_config[`UBG_DLAB_BIT];

  always_comb begin
    st_next = st_reg;
    st_next.rsync = {st_reg.rsync[1:0], ref_clk_i};
    if (st_reg.rsync[2] == st_reg.rsync[1]) begin
      st_next.ref_lvl = st_reg.rsync[2];
    end
    st_next.ref_en = st_next.ref_lvl & ~st_reg.ref_lvl;
    st_next.src_prev = src;
    if (wr_i) begin
      if (hit(addr_i, `UBG_OFF_DIV_LOW) && dlab) begin
        st_next.div_lo = wdata_i;
      end else if (hit(addr_i, `UBG_OFF_IRQ_EN) && dlab) begin
        st_next.div_hi = wdata_i;
      end else if (hit(addr_i, `UBG_OFF_IRQ_EN)) begin
        st_next.irq_enable = wdata_i & `UBG_IEN_MASK;
      end else if (hit(addr_i, `UBG_OFF_SPEED)) begin
        st_next.speed_mode_config = wdata_i;
      end else if (hit(addr_i, `UBG_OFF_MODEM_CTL)) begin
        st_next.modem_control_reg = wdata_i;
      end else if (hit(addr_i, `UBG_OFF_IRQ_MASK)) begin
        st_next.ev_mask = wdata_i[3:0];
      end else if (hit(addr_i, `UBG_OFF_SCRATCH)) begin
        st_next.scratch_byte = wdata_i;
      end
    end
    st_next.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `UBG_OFF_DIV_LOW: st_next.rdata = dlab ? st_reg.div_lo : 8'h00;
        `UBG_OFF_IRQ_EN: begin
          st_next.rdata = dlab ? st_reg.div_hi : st_reg.irq_enable;
        end
        `UBG_OFF_IRQ_STAT: begin
          st_next.rdata = {4'h0, st_reg.ev_stat};
          st_next.ev_stat = 4'h0;
        end
        `UBG_OFF_SPEED:     st_next.rdata = st_reg.speed_mode_config;
        `UBG_OFF_MODEM_CTL: st_next.rdata = st_reg.modem_control_reg;
        `UBG_OFF_IRQ_MASK:  st_next.rdata = {4'h0, st_reg.ev_mask};
        `UBG_OFF_SCRATCH:   st_next.rdata = st_reg.scratch_byte;
        default:            st_next.rdata = 8'h00;
      endcase
    end
    // Set wins over read clear.
    st_next.ev_stat = st_next.ev_stat | (src & ~st_reg.src_prev);
    st_next.irq = st_reg.modem_control_reg[`UBG_MCR_OUT_EN]
      & |(src & st_reg.irq_enable[3:0]);
    st_next.ev_irq = |(st_next.ev_stat & st_next.ev_mask);
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.div_lo <= 8'(`UBG_DIV_RESET);
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.ref_en = st_reg.ref_en;
  assign tif.divisor = {st_reg.div_hi, st_reg.div_lo};
  assign tif.hs_mode = (st_reg.speed_mode_config[`UBG_SPEED_HS_LO +: 2]
                        == `UBG_HS_CODE);
  always_comb begin
    case (st_reg.speed_mode_config[`UBG_SPEED_PRE_LO +: 2])
      2'h1:    tif.pre_sel = ubg_pkg::UBG_PRE_1625;
      2'h2:    tif.pre_sel = ubg_pkg::UBG_PRE_1;
      default: tif.pre_sel = ubg_pkg::UBG_PRE_13;
    endcase
  end

  ubg_prediv u_gen (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .tif     (tif)
  );

  assign rdata_o = st_reg.rdata;
  assign irq_o = st_reg.irq;
  assign ev_irq_o = st_reg.ev_irq;
  assign tick16_o = tif.tick16;
endmodule

//--- core/ubg_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 25 MHz system clock, 24 MHz reference enable supplied by caller.
// Notes:   Register offsets follow the legacy port layout.
`ifndef UBG_CFG_SVH
`define UBG_CFG_SVH

`define UBG_ADDR_W        3
`define UBG_OFF_DIV_LOW   3'h0
`define UBG_OFF_IRQ_EN    3'h1
`define UBG_OFF_DIV_HIGH  3'h1
`define UBG_OFF_IRQ_STAT  3'h2
`define UBG_OFF_SPEED     3'h3
`define UBG_OFF_MODEM_CTL 3'h4
`define UBG_OFF_IRQ_MASK  3'h5
`define UBG_OFF_SCRATCH   3'h7
`define UBG_DLAB_BIT      7
`define UBG_SPEED_PRE_LO  0
`define UBG_SPEED_HS_LO   6
`define UBG_MCR_OUT_EN    3
`define UBG_IEN_RX        0
`define UBG_IEN_TX        1
`define UBG_IEN_LINE      2
`define UBG_IEN_MODEM     3
`define UBG_IEN_MASK      8'h0F
`define UBG_DIV_RESET     16'h000C
`define UBG_PRE_13_RESET  2'h0
`define UBG_PRE13_HALF    4'hD
`define UBG_PRE1625_NUM   5'h08
`define UBG_PRE1625_DEN   5'h0D
`define UBG_HS_CODE       2'h3

`endif

//--- core/ubg_pkg.sv
// Purpose: Shared types of the interrupt enable and baud generator block.
// Assumes: Constants live in ubg_cfg.svh.
// Notes:   None.
package ubg_pkg;
  typedef enum logic [1:0] {
    UBG_PRE_13,
    UBG_PRE_1625,
    UBG_PRE_1
  } ubg_pre_t;
endpackage

//--- core/ubg_tick_if.sv
// Purpose: Carries the reference enable and divisor to the generator.
// Assumes: Single clock domain.
// Notes:   None.
`timescale 1ns/100ps
interface ubg_tick_if;
  logic           ref_en;
  logic [15:0]    divisor;
  ubg_pkg::ubg_pre_t pre_sel;
  logic           hs_mode;
  logic           tick16;
  modport ctrl (output ref_en, output divisor, output pre_sel,
                output hs_mode, input tick16);
  modport gen  (input ref_en, input divisor, input pre_sel,
                input hs_mode, output tick16);
endinterface

//--- core/ubg_prediv.sv
// Purpose: Pre-divider and divisor counter producing the 16x sample tick.
// Assumes: ref_en pulses once per 24 MHz reference period.
// Notes:   Divide by 1.625 alternates spacing by fractional accumulation.
`timescale 1ns/100ps
`include "ubg_cfg.svh"
module ubg_prediv (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  ubg_tick_if.gen   tif
);
  typedef struct packed {
    logic [3:0]  pre_cnt;
    logic [4:0]  frac;
    logic [15:0] div_cnt;
    logic        tick;
  } ubg_gen_st_t;

  ubg_gen_st_t st_reg;
  ubg_gen_st_t st_next;
  logic        base_en;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    base_en = 1'b0;
    if (tif.ref_en) begin
      if (tif.hs_mode || tif.pre_sel == ubg_pkg::UBG_PRE_1) begin
        base_en = 1'b1;
      end else if (tif.pre_sel == ubg_pkg::UBG_PRE_1625) begin
        if (st_reg.frac + `UBG_PRE1625_NUM >= `UBG_PRE1625_DEN) begin
          st_next.frac = 5'(st_reg.frac + `UBG_PRE1625_NUM
                            - `UBG_PRE1625_DEN);
          base_en = 1'b1;
        end else begin
          st_next.frac = 5'(st_reg.frac + `UBG_PRE1625_NUM);
        end
      end else begin
        if (st_reg.pre_cnt >= 4'(`UBG_PRE13_HALF - 4'h1)) begin
          st_next.pre_cnt = 4'h0;
          base_en = 1'b1;
        end else begin
          st_next.pre_cnt = 4'(st_reg.pre_cnt + 4'h1);
        end
      end
    end
    if (base_en) begin
      if (st_reg.div_cnt <= 16'h0001) begin
        st_next.div_cnt = tif.divisor;
        st_next.tick = 1'b1;
      end else begin
        st_next.div_cnt = 16'(st_reg.div_cnt - 16'h0001);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.tick16 = st_reg.tick;
endmodule

//--- dv/ubg_chk.sv
// Purpose: Port assertions of the baud generator block.
// Assumes: One clock, nrst_i active low.
// Notes:   Bound to ubg_ctrl.
`timescale 1ns/100ps
`include "ubg_cfg.svh"
module ubg_chk (
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic       ref_clk_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       rx_ready_i,
  input wire logic       tx_empty_i,
  input wire logic       line_status_i,
  input wire logic       modem_change_i,
  input wire logic [7:0] rdata_o,
  input wire logic       irq_o,
  input wire logic       ev_irq_o,
  input wire logic       tick16_o
);
  logic [3:0] src;
  logic       any;
  logic       acc;
  assign src = {modem_change_i, line_status_i, tx_empty_i, rx_ready_i};
  assign any = |src;
  assign acc = rd_i | wr_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its slot");
  a_tick_single: assert property (tick16_o |=> !tick16_o)
    else $error("tick longer than one cycle");
  a_unmapped_zero: assert property (rd_i && addr_i == 3'h6
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_scratch_echo: assert property (wr_i && addr_i == `UBG_OFF_SCRATCH
    ##1 rd_i && addr_i == `UBG_OFF_SCRATCH |=> rdata_o == $past(wdata_i, 2))
    else $error("scratch byte lost");
  a_irq_quiet: assert property (!any [*5] |-> !irq_o)
    else $error("interrupt without source");
  a_irq_cause: assert property ($rose(irq_o) |-> any || $past(any)
    || $past(any, 2) || $past(any, 3)) else $error("interrupt rose alone");
  a_irq_steady: assert property (($stable(src) && !wr_i) [*5]
    |-> $stable(irq_o)) else $error("interrupt moved alone");
  a_ev_fall: assert property ($fell(ev_irq_o) |-> $past(acc)
    || $past(acc, 2) || $past(acc, 3)) else $error("event cleared alone");
endmodule
bind ubg_ctrl ubg_chk chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .ref_clk_i(ref_clk_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rx_ready_i(rx_ready_i), .tx_empty_i(tx_empty_i),
  .line_status_i(line_status_i), .modem_change_i(modem_change_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .ev_irq_o(ev_irq_o),
  .tick16_o(tick16_o));

//--- dv/ubg_peer.sv
// Purpose: Reference clock source of the generator.
// Assumes: Reference runs free at a quarter of mclk_i.
// Notes:   Rates are checked in mclk_i cycles.
`timescale 1ns/100ps
module ubg_peer (
  input  wire logic mclk_i,
  output wire logic ref_clk_o
);
  logic [1:0] cnt_reg = 2'h0;
  always @(posedge mclk_i) cnt_reg <= cnt_reg + 2'h1;
  assign ref_clk_o = cnt_reg[1];
endmodule

//--- dv/testbench.sv
// Purpose: Register and rate tests of the baud generator block.
// Assumes: Reference period of four clocks.
// Notes:   Divisor 3 is used for rate checks.
`timescale 1ns/100ps
module testbench;
  logic       mclk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, ref_clk;
  logic [2:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o;
  logic [3:0] src = 0;
  logic       irq_o, ev_irq_o, tick16_o;
  int         error_cnt = 0, tests_run = 0, n, cyc;
  logic [7:0] code [4] = '{8'h00, 8'h01, 8'h02, 8'hC0};
  int         span [4] = '{8*3*13*4, 3*13*4, 8*3*4, 8*3*4};
  initial forever #20 mclk_i = ~mclk_i;
  ubg_peer peer (.mclk_i(mclk_i), .ref_clk_o(ref_clk));
  ubg_ctrl dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .ref_clk_i(ref_clk),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rx_ready_i(src[0]), .tx_empty_i(src[1]), .line_status_i(src[2]),
    .modem_change_i(src[3]), .rdata_o(rdata_o), .irq_o(irq_o),
    .ev_irq_o(ev_irq_o), .tick16_o(tick16_o));
  task automatic chk(input logic [15:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input int a, input logic [7:0] d);
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    addr_i <= 3'(a);
    wdata_i <= d;
    @(posedge mclk_i);
  endtask
  task automatic rd(input int a, input logic [7:0] e, string w);
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    addr_i <= 3'(a);
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(16'(rdata_o), 16'(e), w);
  endtask
  task automatic idle(input int k);
    wr_i <= 1'b0;
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(1, 8'h00, "irq_enable");
    wr(1, 8'hFF);
    rd(1, 8'h0F, "irq_enable");
    rd(6, 8'h00, "unmapped");
    wr(7, 8'hA5);
    rd(7, 8'hA5, "scratch_byte");
    $display("test registers done");
    wr(4, 8'h08);
    for (int e = 0; e < 5; e++) for (int s = 0; s < 4; s++) begin
      wr(1, (e < 4) ? (8'h01 << e) : 8'h00);
      src <= 4'h1 << s;
      idle(6);
      chk(16'(irq_o), 16'(e == s), "irq_o");
    end
    wr(1, 8'h0F);
    src <= 4'hF;
    for (int m = 0; m < 2; m++) begin
      wr(4, m ? 8'h08 : 8'h00);
      idle(6);
      chk(16'(irq_o), 16'(m), "irq_o master");
    end
    src <= 4'h0;
    wr(5, 8'h0F);
    idle(4);
    chk(16'(ev_irq_o), 16'h0001, "ev_irq_o");
    rd(2, 8'h0F, "event status");
    rd(2, 8'h00, "event status");
    idle(4);
    chk(16'(ev_irq_o), 16'h0000, "ev_irq_o");
    $display("test interrupts done");
    wr(3, 8'h80);
    rd(0, 8'h0C, "divisor reset");
    wr(0, 8'h34);
    wr(1, 8'h12);
    rd(0, 8'h34, "divisor low");
    rd(1, 8'h12, "divisor high");
    wr(0, 8'h03);
    wr(1, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(3, code[c]);
      idle(1);
      n = 0;
      cyc = 0;
      for (int i = 0; i < 5000 && n < 10; i++) begin
        @(posedge mclk_i);
        #1 if (n >= 2) cyc++;
        if (tick16_o === 1'b1) n++;
      end
      chk(16'(cyc), 16'(span[c]), "tick span");
    end
    $display("test rates done");
    end_of_test();
  end
endmodule
